/* File: ump_pkg.sv */
package ump_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_PULL_UP   = 10'h014;
  localparam logic [9:0] IDX_PULL_DOWN = 10'h015;
  localparam logic [9:0] IDX_LOOP      = 10'h016;
  localparam logic [9:0] IDX_INFRARED  = 10'h017;
  localparam logic [9:0] IDX_CLK_OUT   = 10'h018;
  localparam logic [9:0] IDX_WAKE      = 10'h01f;
  localparam logic [9:0] IDX_INT_STAT  = 10'h020;
  localparam logic [9:0] IDX_INT_MASK  = 10'h021;

  // ==========================================================
  // Reset values and writable-bit masks
  localparam logic [15:0] PULL_UP_RST   = 16'h07ff;
  localparam logic [15:0] PULL_DOWN_RST = 16'h0000;
  localparam logic [15:0] LOOP_RST      = 16'h0000;
  localparam logic [15:0] INFRARED_RST  = 16'h0000;
  localparam logic [15:0] CLK_OUT_RST   = 16'h0000;
  localparam logic [15:0] WAKE_RST      = 16'h0004;
  localparam logic [15:0] INT_STAT_RST  = 16'h0000;
  localparam logic [15:0] INT_MASK_RST  = 16'h0000;
  localparam logic [15:0] PULL_MASK     = 16'h07ff;
  localparam logic [15:0] LOOP_MASK     = 16'h0007;
  localparam logic [15:0] INFRARED_MASK = 16'h0007;
  localparam logic [15:0] CLK_OUT_MASK  = 16'hffff;
  localparam logic [15:0] WAKE_MASK     = 16'h000c;
  localparam logic [15:0] INT_MASK      = 16'h0007;

  // ==========================================================
  // Field positions
  localparam int RX_PULL_BIT    = 10;
  localparam int GPIO_PULL_LSB  = 0;
  localparam int LOOP_DTR_DSR   = 2;
  localparam int LOOP_RTS_CTS   = 1;
  localparam int LOOP_TX_RX     = 0;
  localparam int IR_WIDE_PULSE  = 2;
  localparam int IR_RX_INVERT   = 1;
  localparam int IR_ENABLE      = 0;
  localparam int CLK_HIGH_LSB   = 8;
  localparam int CLK_LOW_LSB    = 0;
  localparam int WAKE_RX_EN     = 3;
  localparam int WAKE_RING_EN   = 2;
  localparam int EV_RX_WAKE     = 0;
  localparam int EV_RING_WAKE   = 1;
  localparam int EV_WAKE_REQ    = 2;

  // ==========================================================
  // Timing
  localparam logic [3:0] IR_NARROW_TICKS = 4'h3;
  localparam logic [3:0] IR_WIDE_TICKS   = 4'h4;
  localparam logic [3:0] IR_HOLD_TICKS   = 4'hf;
  localparam int MCLK_PERIOD_PS  = 20000;
  localparam int CLK_OUT_STEP_PS = 41670;

  // ==========================================================
  // Clock output phases
  typedef enum logic [1:0] {
    CG_IDLE = 2'b00,
    CG_HIGH = 2'b01,
    CG_LOW  = 2'b11
  } ump_clk_phase_type;

endpackage

/* File: ump_clk_out_gen.sv */
`timescale 1ns/1ps

module ump_clk_out_gen (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // Period settings in output steps
  input  wire logic [7:0] highSpan,
  input  wire logic [7:0] lowSpan,
  // Generated clock
  output logic            clkOut
);

  typedef struct packed {
    ump_pkg::ump_clk_phase_type phase;
    logic [16:0]                acc;
    logic [7:0]                 count;
    logic                       out;
  } ump_clk_state_type;

  localparam logic [16:0] STEP_PS = 17'(ump_pkg::CLK_OUT_STEP_PS);
  localparam logic [16:0] MCLK_PS = 17'(ump_pkg::MCLK_PERIOD_PS);

  ump_clk_state_type s_reg;
  ump_clk_state_type s_next;
  logic [16:0]       sum;
  logic              tick;
  logic [7:0]        countInc;

  always_comb begin
    s_next   = s_reg;
    // Fractional step: average tick rate matches the step time exactly
    sum      = s_reg.acc + MCLK_PS;
    tick     = (sum >= STEP_PS);
    s_next.acc = tick ? (sum - STEP_PS) : sum;
    countInc = s_reg.count + 8'h01;
    unique case (s_reg.phase)
      ump_pkg::CG_IDLE: begin
        s_next.count = 8'h00;
        if (highSpan != 8'h00) begin
          s_next.phase = ump_pkg::CG_HIGH;
        end else if (lowSpan != 8'h00) begin
          s_next.phase = ump_pkg::CG_LOW;
        end
      end
      ump_pkg::CG_HIGH: begin
        if (tick) begin
          s_next.count = countInc;
          if (countInc >= highSpan) begin
            s_next.count = 8'h00;
            if (lowSpan != 8'h00) begin
              s_next.phase = ump_pkg::CG_LOW;
            end else if (highSpan == 8'h00) begin
              s_next.phase = ump_pkg::CG_IDLE;
            end
          end
        end
      end
      ump_pkg::CG_LOW: begin
        if (tick) begin
          s_next.count = countInc;
          if (countInc >= lowSpan) begin
            s_next.count = 8'h00;
            if (highSpan != 8'h00) begin
              s_next.phase = ump_pkg::CG_HIGH;
            end else if (lowSpan == 8'h00) begin
              s_next.phase = ump_pkg::CG_IDLE;
            end
          end
        end
      end
      default: begin
        s_next.phase = ump_pkg::CG_IDLE;
        s_next.count = 8'h00;
      end
    endcase
    s_next.out = (s_next.phase == ump_pkg::CG_HIGH);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_reg <= '{phase: ump_pkg::CG_IDLE, acc: 17'h00000,
                 count: 8'h00, out: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign clkOut = s_reg.out;

endmodule // ump_clk_out_gen

/* File: ump_pin_misc_ctrl.sv */
`timescale 1ns/1ps

module ump_pin_misc_ctrl #(
  parameter int GPIO_COUNT = 10
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  srst,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // UART core side
  input  wire logic                  coreTxd,
  input  wire logic                  coreRts,
  input  wire logic                  coreDtr,
  input  wire logic                  sampleTick,
  output logic                       coreRxd,
  output logic                       coreCts,
  output logic                       coreDsr,
  // UART and modem pins
  input  wire logic                  rxPin,
  input  wire logic                  ctsPin,
  input  wire logic                  dsrPin,
  input  wire logic                  ringWakePin,
  output logic                       txPin,
  output logic                       txPinOe,
  // Pin direction and pull resistor controls
  input  wire logic                  rxIsInput,
  input  wire logic                  ringIsInput,
  input  wire logic [GPIO_COUNT-1:0] gpioIsInput,
  output logic                       rxPullUp,
  output logic                       rxPullDown,
  output logic [GPIO_COUNT-1:0]      gpioPullUp,
  output logic [GPIO_COUNT-1:0]      gpioPullDown,
  // Clock output
  output logic                       clkOutPin,
  // USB power state and wakeup
  input  wire logic                  suspended,
  input  wire logic                  remoteWakeAllowed,
  output logic                       wakeRequest,
  // Interrupt
  output logic                       irq
);

  // ==========================================================
  // Parameter check
  if (GPIO_COUNT < 1 || GPIO_COUNT > 10) begin : g_bad_count
    $error("GPIO_COUNT must lie between 1 and 10");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0]           pullUpReg;
    logic [15:0]           pullDownReg;
    logic [15:0]           loopReg;
    logic [15:0]           irReg;
    logic [15:0]           clkReg;
    logic [15:0]           wakeReg;
    logic [15:0]           intStat;
    logic [15:0]           intMask;
    logic [31:0]           rdData;
    logic                  ready;
    logic                  slvErr;
    logic [GPIO_COUNT-1:0] gpioPu;
    logic [GPIO_COUNT-1:0] gpioPd;
    logic                  rxPu;
    logic                  rxPd;
    logic                  txOut;
    logic                  txOe;
    logic                  rxOut;
    logic                  ctsOut;
    logic                  dsrOut;
    logic [3:0]            txPhase;
    logic                  lastTxd;
    logic [3:0]            rxHold;
    logic                  rxPrev;
    logic                  ringPrev;
    logic                  wakeReq;
    logic                  irqOut;
  } ump_state_type;

  ump_state_type s_reg;
  ump_state_type s_next;

  // ==========================================================
  // Combinational helpers
  logic        setupPhase;
  logic        accessDone;
  logic [9:0]  regIndex;
  logic        addrHit;
  logic [15:0] rdWord;
  logic [15:0] wrWord;
  logic        irOn;
  logic [3:0]  pulseTicks;
  logic        irTx;
  logic        rxRaw;
  logic        rxDecoded;
  logic        rxFall;
  logic        ringFall;
  logic        rxWakeEv;
  logic        ringWakeEv;
  logic        wakeEv;
  logic [15:0] events;
  logic [15:0] readClear;

  always_comb begin
    s_next     = s_reg;
    setupPhase = psel && !penable;
    accessDone = psel && penable && s_reg.ready;
    regIndex   = paddr[11:2];
    wrWord     = pwdata[15:0];
    addrHit    = 1'b1;
    rdWord     = 16'h0000;

    // ---- Register decode, answered one cycle after setup
    unique case (regIndex)
      ump_pkg::IDX_PULL_UP:   rdWord = s_reg.pullUpReg;
      ump_pkg::IDX_PULL_DOWN: rdWord = s_reg.pullDownReg;
      ump_pkg::IDX_LOOP:      rdWord = s_reg.loopReg;
      ump_pkg::IDX_INFRARED:  rdWord = s_reg.irReg;
      ump_pkg::IDX_CLK_OUT:   rdWord = s_reg.clkReg;
      ump_pkg::IDX_WAKE:      rdWord = s_reg.wakeReg;
      ump_pkg::IDX_INT_STAT:  rdWord = s_reg.intStat;
      ump_pkg::IDX_INT_MASK:  rdWord = s_reg.intMask;
      default:                addrHit = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00) begin
      addrHit = 1'b0;
    end
    s_next.ready  = setupPhase;
    s_next.slvErr = setupPhase && !addrHit;
    if (setupPhase) begin
      s_next.rdData = (addrHit && !pwrite) ? {16'h0000, rdWord} : 32'h0;
    end

    // Writes; reserved bits are stored as zero regardless
    readClear = 16'h0000;
    if (accessDone && addrHit && pwrite) begin
      unique case (regIndex)
        ump_pkg::IDX_PULL_UP:
          s_next.pullUpReg = wrWord & ump_pkg::PULL_MASK;
        ump_pkg::IDX_PULL_DOWN:
          s_next.pullDownReg = wrWord & ump_pkg::PULL_MASK;
        ump_pkg::IDX_LOOP:
          s_next.loopReg = wrWord & ump_pkg::LOOP_MASK;
        ump_pkg::IDX_INFRARED:
          s_next.irReg = wrWord & ump_pkg::INFRARED_MASK;
        ump_pkg::IDX_CLK_OUT:
          s_next.clkReg = wrWord & ump_pkg::CLK_OUT_MASK;
        ump_pkg::IDX_WAKE:
          s_next.wakeReg = wrWord & ump_pkg::WAKE_MASK;
        ump_pkg::IDX_INT_MASK:
          s_next.intMask = wrWord & ump_pkg::INT_MASK;
        default: ;
      endcase
    end
    // Clear only what the read returned, so later events survive
    if (accessDone && addrHit && !pwrite
        && regIndex == ump_pkg::IDX_INT_STAT) begin
      readClear = s_reg.rdData[15:0];
    end

    // ---- Pull resistors, gated by input direction
    for (int i = 0; i < GPIO_COUNT; i++) begin
      s_next.gpioPu[i] = s_reg.pullUpReg[ump_pkg::GPIO_PULL_LSB + i]
                         && gpioIsInput[i];
      s_next.gpioPd[i] = s_reg.pullDownReg[ump_pkg::GPIO_PULL_LSB + i]
                         && !s_reg.pullUpReg[ump_pkg::GPIO_PULL_LSB + i]
                         && gpioIsInput[i];
    end
    s_next.rxPu = s_reg.pullUpReg[ump_pkg::RX_PULL_BIT]
                  && rxIsInput;
    s_next.rxPd = s_reg.pullDownReg[ump_pkg::RX_PULL_BIT]
                  && !s_reg.pullUpReg[ump_pkg::RX_PULL_BIT]
                  && rxIsInput;

    // ---- Infrared transmit: pulse at the start of each zero bit
    irOn       = s_reg.irReg[ump_pkg::IR_ENABLE];
    pulseTicks = s_reg.irReg[ump_pkg::IR_WIDE_PULSE]
                 ? ump_pkg::IR_WIDE_TICKS
                 : ump_pkg::IR_NARROW_TICKS;
    s_next.lastTxd = coreTxd;
    if (coreTxd != s_reg.lastTxd) begin
      // Bit phase realigns on every data edge
      s_next.txPhase = 4'h0;
    end else if (sampleTick) begin
      s_next.txPhase = s_reg.txPhase + 4'h1;
    end
    irTx = !coreTxd && (s_reg.txPhase < pulseTicks);
    s_next.txOut = irOn ? irTx : coreTxd;
    s_next.txOe  = !s_reg.loopReg[ump_pkg::LOOP_TX_RX];

    // ---- Infrared receive: a low pulse stretches to one zero bit
    rxRaw = rxPin ^ (irOn && s_reg.irReg[ump_pkg::IR_RX_INVERT]);
    if (!rxRaw) begin
      s_next.rxHold = ump_pkg::IR_HOLD_TICKS;
    end else if (sampleTick && s_reg.rxHold != 4'h0) begin
      s_next.rxHold = s_reg.rxHold - 4'h1;
    end
    rxDecoded = irOn ? (rxRaw && s_reg.rxHold == 4'h0) : rxPin;
    s_next.rxOut = s_reg.loopReg[ump_pkg::LOOP_TX_RX]
                   ? coreTxd : rxDecoded;

    // ---- Modem loopback paths
    s_next.ctsOut = s_reg.loopReg[ump_pkg::LOOP_RTS_CTS]
                    ? coreRts : ctsPin;
    s_next.dsrOut = s_reg.loopReg[ump_pkg::LOOP_DTR_DSR]
                    ? coreDtr : dsrPin;

    // ---- Wakeup sources
    s_next.rxPrev   = rxPin;
    s_next.ringPrev = ringWakePin;
    rxFall     = s_reg.rxPrev && !rxPin;
    ringFall   = s_reg.ringPrev && !ringWakePin;
    rxWakeEv   = rxFall && rxIsInput
                 && s_reg.wakeReg[ump_pkg::WAKE_RX_EN];
    ringWakeEv = ringFall && ringIsInput
                 && s_reg.wakeReg[ump_pkg::WAKE_RING_EN];
    wakeEv     = (rxWakeEv || ringWakeEv)
                 && suspended && remoteWakeAllowed;
    s_next.wakeReq = wakeEv;

    // ---- Interrupt status: set wins over read clear
    events = 16'h0000;
    events[ump_pkg::EV_RX_WAKE]   = rxWakeEv;
    events[ump_pkg::EV_RING_WAKE] = ringWakeEv;
    events[ump_pkg::EV_WAKE_REQ]  = wakeEv;
    s_next.intStat = ((s_reg.intStat & ~readClear) | events)
                     & ump_pkg::INT_MASK;
    s_next.irqOut  = |(s_next.intStat & s_next.intMask);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_reg             <= '0;
      s_reg.pullUpReg   <= ump_pkg::PULL_UP_RST;
      s_reg.pullDownReg <= ump_pkg::PULL_DOWN_RST;
      s_reg.loopReg     <= ump_pkg::LOOP_RST;
      s_reg.irReg       <= ump_pkg::INFRARED_RST;
      s_reg.clkReg      <= ump_pkg::CLK_OUT_RST;
      s_reg.wakeReg     <= ump_pkg::WAKE_RST;
      s_reg.intStat     <= ump_pkg::INT_STAT_RST;
      s_reg.intMask     <= ump_pkg::INT_MASK_RST;
      s_reg.txOut       <= 1'b1;
      s_reg.txOe        <= 1'b1;
      s_reg.rxOut       <= 1'b1;
      s_reg.lastTxd     <= 1'b1;
      s_reg.rxPrev      <= 1'b1;
      s_reg.ringPrev    <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Output clock generator
  ump_clk_out_gen u_clk_out (
    .mclk     (mclk),
    .srst     (srst),
    .highSpan (s_reg.clkReg[ump_pkg::CLK_HIGH_LSB +: 8]),
    .lowSpan  (s_reg.clkReg[ump_pkg::CLK_LOW_LSB +: 8]),
    .clkOut   (clkOutPin)
  );

  // ==========================================================
  // Outputs, all from flip-flops
  assign prdata       = s_reg.rdData;
  assign pready       = s_reg.ready;
  assign pslverr      = s_reg.slvErr;
  assign coreRxd      = s_reg.rxOut;
  assign coreCts      = s_reg.ctsOut;
  assign coreDsr      = s_reg.dsrOut;
  assign txPin        = s_reg.txOut;
  assign txPinOe      = s_reg.txOe;
  assign rxPullUp     = s_reg.rxPu;
  assign rxPullDown   = s_reg.rxPd;
  assign gpioPullUp   = s_reg.gpioPu;
  assign gpioPullDown = s_reg.gpioPd;
  assign wakeRequest  = s_reg.wakeReq;
  assign irq          = s_reg.irqOut;

endmodule // ump_pin_misc_ctrl

/* File: ump_pin_misc_ctrl_chk.sv */
`timescale 1ns/1ps

// =========
// Port checker
module ump_pin_misc_ctrl_chk #(
  parameter int GPIO_COUNT = 10
) (
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  srst,
  // APB
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Serial and modem paths
  input wire logic                  coreTxd,
  input wire logic                  coreRts,
  input wire logic                  coreRxd,
  input wire logic                  coreCts,
  input wire logic                  ctsPin,
  input wire logic                  rxPin,
  input wire logic                  ringWakePin,
  input wire logic                  txPinOe,
  // Pulls
  input wire logic [GPIO_COUNT-1:0] gpioIsInput,
  input wire logic                  rxPullUp,
  input wire logic                  rxPullDown,
  input wire logic [GPIO_COUNT-1:0] gpioPullUp,
  input wire logic [GPIO_COUNT-1:0] gpioPullDown,
  // Clock output and wakeup
  input wire logic                  clkOutPin,
  input wire logic                  suspended,
  input wire logic                  remoteWakeAllowed,
  input wire logic                  wakeRequest
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  logic       rxLast, ringLast;
  logic [2:0] fallAge;

  // Age of the latest falling pin edge, saturating
  always_ff @(posedge mclk) begin
    rxLast   <= rxPin;
    ringLast <= ringWakePin;
    if (srst) begin
      fallAge <= 3'h7;
    end else if ((rxLast && !rxPin) || (ringLast && !ringWakePin)) begin
      fallAge <= 3'h0;
    end else if (fallAge != 3'h7) begin
      fallAge <= fallAge + 3'h1;
    end
  end

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence

  property p_ready;
    s_setup |=> s_access;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_excl;
    (gpioPullUp & gpioPullDown) == '0 && !(rxPullUp && rxPullDown);
  endproperty
  property p_dir;
    (gpioIsInput == '0)[*3] |-> gpioPullUp == '0 && gpioPullDown == '0;
  endproperty
  property p_loop_tx;
    !$past(srst) && !txPinOe |-> coreRxd == $past(coreTxd);
  endproperty
  property p_cts;
    !$past(srst) |-> coreCts == $past(ctsPin) || coreCts == $past(coreRts);
  endproperty
  property p_wake_gate;
    wakeRequest |-> $past(suspended) && $past(remoteWakeAllowed);
  endproperty
  property p_wake_src;
    wakeRequest |-> fallAge <= 3'h3;
  endproperty
  property p_clk_hi;
    $rose(clkOutPin) |=> clkOutPin;
  endproperty
  property p_clk_lo;
    $fell(clkOutPin) |=> !clkOutPin;
  endproperty

  a_ready: assert property (p_ready)
    else $error("no answer");
  a_err: assert property (p_err)
    else $error("stray error");
  a_excl: assert property (p_excl)
    else $error("both pulls on");
  a_dir: assert property (p_dir)
    else $error("pull on output");
  a_loop_tx: assert property (p_loop_tx)
    else $error("loop broken");
  a_cts: assert property (p_cts)
    else $error("bad CTS source");
  a_wake_gate: assert property (p_wake_gate)
    else $error("wake not permitted");
  a_wake_src: assert property (p_wake_src)
    else $error("wake without edge");
  a_clk_hi: assert property (p_clk_hi)
    else $error("short high");
  a_clk_lo: assert property (p_clk_lo)
    else $error("short low");
endmodule // ump_pin_misc_ctrl_chk

bind ump_pin_misc_ctrl ump_pin_misc_ctrl_chk #(
  .GPIO_COUNT(GPIO_COUNT)
) i_chk (
  .mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .coreTxd(coreTxd),
  .coreRts(coreRts), .coreRxd(coreRxd), .coreCts(coreCts),
  .ctsPin(ctsPin), .rxPin(rxPin), .ringWakePin(ringWakePin),
  .txPinOe(txPinOe), .gpioIsInput(gpioIsInput), .rxPullUp(rxPullUp),
  .rxPullDown(rxPullDown), .gpioPullUp(gpioPullUp),
  .gpioPullDown(gpioPullDown), .clkOutPin(clkOutPin),
  .suspended(suspended), .remoteWakeAllowed(remoteWakeAllowed),
  .wakeRequest(wakeRequest)
);

/* File: ump_peer_model.sv */
`timescale 1ns/1ps

// =========
// Far-side peripheral on the serial and modem pins
module ump_peer_model (
  // Clock
  input  wire logic mclk,
  // Levels commanded by the bench
  input  wire logic rxDrive,
  input  wire logic rxLevel,
  input  wire logic ringLevel,
  input  wire logic ctsLevel,
  input  wire logic dsrLevel,
  // Pulls on the receive line
  input  wire logic rxPullUp,
  input  wire logic rxPullDown,
  // Lines into the device
  output logic      rxPin,
  output logic      ringWakePin,
  output logic      ctsPin,
  output logic      dsrPin
);
  logic floatBit = 1'b0;

  // Unpulled line wanders, so no stale level passes
  always @(posedge mclk) floatBit <= ~floatBit;

  always_comb begin
    if (rxDrive) rxPin = rxLevel;
    else if (rxPullUp) rxPin = 1'b1;
    else if (rxPullDown) rxPin = 1'b0;
    else rxPin = floatBit;
  end
  assign ringWakePin = ringLevel;
  assign ctsPin      = ctsLevel;
  assign dsrPin      = dsrLevel;
endmodule // ump_peer_model

/* File: tb.sv */
`timescale 1ns/1ps

// =========
// Bench
module tb;
  logic        mclk = 1'b0, srst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, coreRxd, coreCts, coreDsr, txPin, txPinOe;
  logic        coreTxd = 1'b1, coreRts = 1'b0, coreDtr = 1'b0;
  logic        sampleTick = 1'b0, rxIsInput = 1'b1;
  logic        rxPin, ctsPin, dsrPin, ringWakePin;
  logic        rxDrive = 1'b1, rxLevel = 1'b1, ringLevel = 1'b1;
  logic        ctsLevel = 1'b0, dsrLevel = 1'b0;
  logic [9:0]  gpioIsInput = 10'h3ff;
  logic [9:0]  gpioPullUp, gpioPullDown;
  logic        rxPullUp, rxPullDown, clkOutPin, wakeRequest, irq;
  logic        suspended = 1'b0, remoteWakeAllowed = 1'b0;
  logic [2:0]  tickCnt = 3'h0;
  int          numErrors = 0, testsRun = 0, cycles = 0;

  always #10 mclk = ~mclk;

  // Strobe one cycle in eight; run guard
  always @(posedge mclk) begin
    tickCnt <= tickCnt + 3'h1;
    sampleTick <= (tickCnt == 3'h7);
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      close_out();
    end
  end

  ump_pin_misc_ctrl i_dut (
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .coreTxd(coreTxd),
    .coreRts(coreRts), .coreDtr(coreDtr), .sampleTick(sampleTick),
    .coreRxd(coreRxd), .coreCts(coreCts), .coreDsr(coreDsr),
    .rxPin(rxPin), .ctsPin(ctsPin), .dsrPin(dsrPin),
    .ringWakePin(ringWakePin), .txPin(txPin), .txPinOe(txPinOe),
    .rxIsInput(rxIsInput), .ringIsInput(1'b1),
    .gpioIsInput(gpioIsInput), .rxPullUp(rxPullUp),
    .rxPullDown(rxPullDown), .gpioPullUp(gpioPullUp),
    .gpioPullDown(gpioPullDown), .clkOutPin(clkOutPin),
    .suspended(suspended), .remoteWakeAllowed(remoteWakeAllowed),
    .wakeRequest(wakeRequest), .irq(irq)
  );

  ump_peer_model i_peer (
    .mclk(mclk), .rxDrive(rxDrive), .rxLevel(rxLevel),
    .ringLevel(ringLevel), .ctsLevel(ctsLevel), .dsrLevel(dsrLevel),
    .rxPullUp(rxPullUp), .rxPullDown(rxPullDown), .rxPin(rxPin),
    .ringWakePin(ringWakePin), .ctsPin(ctsPin), .dsrPin(dsrPin)
  );

  // =========
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d errors=%0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Idle cycle keeps one driver per step
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, {16'h0000, d}, r, e);
    chk({31'h0, e}, 32'h0);
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h0, r, e);
    chk(r, exp);
  endtask

  task automatic watch(input int n, output logic s);
    s = 1'b0;
    repeat (n) begin
      @(posedge mclk);
      if (wakeRequest === 1'b1) s = 1'b1;
    end
  endtask

  // =========
  // Scenarios
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    rdc(ump_pkg::IDX_PULL_UP, 32'h7ff);
    rdc(ump_pkg::IDX_PULL_DOWN, 32'h0);
    rdc(ump_pkg::IDX_LOOP, 32'h0);
    rdc(ump_pkg::IDX_INFRARED, 32'h0);
    rdc(ump_pkg::IDX_CLK_OUT, 32'h0);
    rdc(ump_pkg::IDX_WAKE, 32'h4);
    chk({21'h0, rxPullUp, gpioPullUp}, 32'h7ff);
    apb(1'b0, 10'h019, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
  endtask

  task automatic t_pulls();
    wr(ump_pkg::IDX_PULL_DOWN, 16'h07ff);
    cyc(2);
    chk({21'h0, rxPullDown, gpioPullDown}, 32'h0);
    wr(ump_pkg::IDX_PULL_UP, 16'h0155);
    rxDrive <= 1'b0;
    cyc(3);
    chk({21'h0, rxPullUp, gpioPullUp}, 32'h155);
    chk({21'h0, rxPullDown, gpioPullDown}, 32'h6aa);
    chk({31'h0, coreRxd}, 32'h0);
    wr(ump_pkg::IDX_PULL_UP, 16'h0400);
    cyc(3);
    chk({30'h0, coreRxd, rxPullDown}, 32'h2);
    rxIsInput <= 1'b0;
    gpioIsInput <= 10'h000;
    cyc(4);
    chk({10'h0, rxPullUp, rxPullDown, gpioPullUp, gpioPullDown}, 0);
    rxIsInput <= 1'b1;
    gpioIsInput <= 10'h3ff;
    rxDrive <= 1'b1;
    wr(ump_pkg::IDX_PULL_UP, 16'h07ff);
    wr(ump_pkg::IDX_PULL_DOWN, 16'h0000);
  endtask

  task automatic t_loops();
    coreRts <= 1'b1;
    coreDtr <= 1'b1;
    coreTxd <= 1'b0;
    cyc(2);
    chk({txPinOe, coreCts, coreDsr, coreRxd}, 32'h9);
    wr(ump_pkg::IDX_LOOP, 16'h0007);
    cyc(2);
    chk({txPinOe, coreCts, coreDsr, coreRxd}, 32'h6);
    coreTxd <= 1'b1;
    rxLevel <= 1'b0;
    cyc(2);
    chk({31'h0, coreRxd}, 32'h1);
    wr(ump_pkg::IDX_LOOP, 16'h0002);
    cyc(2);
    chk({txPinOe, coreCts, coreDsr, coreRxd}, 32'hc);
    wr(ump_pkg::IDX_LOOP, 16'h0000);
    cyc(2);
    chk({txPinOe, coreCts, coreDsr, coreRxd}, 32'h8);
    rxLevel <= 1'b1;
  endtask

  task automatic ir_pulse(input logic [15:0] mode, input int n);
    int hi;
    hi = 0;
    wr(ump_pkg::IDX_INFRARED, mode);
    cyc(40);
    while (sampleTick !== 1'b1) @(posedge mclk);
    coreTxd <= 1'b0;
    repeat (60) begin
      @(posedge mclk);
      if (txPin === 1'b1) hi++;
    end
    chk({31'h0, hi >= 8 * n - 4 && hi <= 8 * n + 2}, 32'h1);
    coreTxd <= 1'b1;
  endtask

  task automatic t_infrared();
    coreTxd <= 1'b0;
    cyc(2);
    chk({31'h0, txPin}, 32'h0);
    coreTxd <= 1'b1;
    ir_pulse(16'h0001, 3);
    ir_pulse(16'h0005, 4);
    cyc(8 * 17);
    chk({31'h0, coreRxd}, 32'h1);
    wr(ump_pkg::IDX_INFRARED, 16'h0003);
    cyc(3);
    chk({31'h0, coreRxd}, 32'h0);
    wr(ump_pkg::IDX_INFRARED, 16'h0000);
  endtask

  // Step is fractional, so a phase may run one cycle long
  task automatic clk_run(input logic [15:0] v);
    int h, l, eh, el;
    eh = int'(v[15:8]) * ump_pkg::CLK_OUT_STEP_PS / ump_pkg::MCLK_PERIOD_PS;
    el = int'(v[7:0]) * ump_pkg::CLK_OUT_STEP_PS / ump_pkg::MCLK_PERIOD_PS;
    h = 0;
    l = 0;
    wr(ump_pkg::IDX_CLK_OUT, v);
    cyc(20);
    while (clkOutPin !== 1'b0) @(posedge mclk);
    while (clkOutPin !== 1'b1) @(posedge mclk);
    while (clkOutPin === 1'b1) begin
      h++;
      @(posedge mclk);
    end
    while (clkOutPin === 1'b0) begin
      l++;
      @(posedge mclk);
    end
    chk({31'h0, h >= eh && h <= eh + 1}, 32'h1);
    chk({31'h0, l >= el && l <= el + 1}, 32'h1);
  endtask

  task automatic t_wake();
    logic s;
    suspended <= 1'b1;
    remoteWakeAllowed <= 1'b1;
    wr(ump_pkg::IDX_INT_MASK, 16'h0007);
    rxLevel <= 1'b0;
    watch(8, s);
    chk({30'h0, s, irq}, 32'h0);
    ringLevel <= 1'b0;
    watch(8, s);
    chk({30'h0, s, irq}, 32'h3);
    rdc(ump_pkg::IDX_INT_STAT, 32'h6);
    rdc(ump_pkg::IDX_INT_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    ringLevel <= 1'b1;
    rxLevel <= 1'b1;
    remoteWakeAllowed <= 1'b0;
    wr(ump_pkg::IDX_WAKE, 16'h0008);
    rxLevel <= 1'b0;
    watch(8, s);
    chk({31'h0, s}, 32'h0);
    rdc(ump_pkg::IDX_INT_STAT, 32'h1);
    wr(ump_pkg::IDX_INT_MASK, 16'h0000);
    remoteWakeAllowed <= 1'b1;
    rxLevel <= 1'b1;
    cyc(2);
    rxLevel <= 1'b0;
    watch(8, s);
    chk({30'h0, s, irq}, 32'h2);
    rdc(ump_pkg::IDX_INT_STAT, 32'h5);
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_pulls();
    t_loops();
    t_infrared();
    clk_run(16'h0201);
    clk_run(16'h0503);
    t_wake();
    close_out();
  end
endmodule // tb
